// ===== verilog/alt_dram_defines.vh
// timing and field constants for the alternate master dram sequencer
`ifndef ALT_DRAM_DEFINES_VH
`define ALT_DRAM_DEFINES_VH
`define ADDR_W 28
`define ROW_LSB 9
`define SIZE_LONG 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
`define SIZE_LINE 2'h3
`define PORT_32 2'h0
`define PORT_8 2'h1
`define PORT_16 2'h2
`define PAGE_NORMAL 2'h0
`define PAGE_BURST 2'h1
`define PAGE_FAST 2'h2
`define TIMING_W 4
`define BEAT_CNT_W 4
`define COL_STEP_32 28'h0000004
`define COL_STEP_16 28'h0000002
`define COL_STEP_8 28'h0000001
`endif

// ===== verilog/half_cycle_strobes.v
// falling-edge retiming stage for row and column strobes
`timescale 1ns/1ps
module half_cycle_strobes (
   input wire clk,
   input wire reset,
   input wire row_req,
   input wire [3:0] col_req,
   output reg row_strobe_n,
   output reg [3:0] col_strobe_n
);
   // strobes change half a clock after the rising-edge decision
   always @(negedge clk or posedge reset) begin
      if (reset) begin
         row_strobe_n <= 1'b1;
         col_strobe_n <= 4'hF;
      end else begin
         row_strobe_n <= ~row_req;
         col_strobe_n <= ~col_req;
      end
   end
endmodule // half_cycle_strobes

// ===== verilog/phase_counter.v
// down counter used to stretch strobe and precharge phases
`timescale 1ns/1ps
`include "alt_dram_defines.vh"
module phase_counter (
   input wire clk,
   input wire reset,
   input wire load,
   input wire [`TIMING_W-1:0] load_value,
   output wire done
);
   reg [`TIMING_W-1:0] count; // remaining extra cycles
   // done looks at the count only, so a load decided from done forms no loop
   assign done = (count == {`TIMING_W{1'b0}});
   // reload on request, then count down to zero
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= {`TIMING_W{1'b0}};
      end else if (load) begin
         count <= load_value;
      end else if (count != {`TIMING_W{1'b0}}) begin
         count <= count - {{(`TIMING_W-1){1'b0}}, 1'b1};
      end
   end
endmodule // phase_counter

// ===== verilog/alt_master_dram_sequencer.v
// sequencer serving dram transfers started by an alternate bus master
//
// Summary of operation
// - register address and attributes on start strobe
// - drive row address and write strobe
// - assert row strobe on next falling edge
// - column address; drive acknowledge negated
// - column strobes per active byte lanes
// - acknowledge one rising edge before beat end
// - nonburst end: negate strobes, float address
// - float acknowledge one clock after negation
// - burst when operand wider than port
// - normal burst: precharge, row, incremented column
// - normal burst five then four clocks
// - page burst keeps row strobe asserted
// - page burst five then two clocks
// - fast page bank acts as page burst
// - page-mode nonburst uses normal sequence
// - timing register lengthens strobe and precharge
// - address drive disable floats address bus
// - never drive the data bus
// - wait for refresh and row precharge
`timescale 1ns/1ps
`include "alt_dram_defines.vh"
module alt_master_dram_sequencer (
   input wire clk,
   input wire reset,
   // alternate master bus side
   input wire transfer_start_strobe_n,
   input wire [`ADDR_W-1:0] addr_in,
   input wire read_not_write,
   input wire [1:0] operand_width_code,
   output reg [`ADDR_W-1:0] addr_out,
   output reg addr_oe_n,
   output reg transfer_acknowledge_n,
   output reg transfer_acknowledge_oe_n,
   output wire data_oe_n,
   // dram side
   output wire row_strobe_n,
   output wire [3:0] col_strobe_n,
   output reg dram_write_strobe,
   // bank decode and configuration from the rest of the controller
   input wire bank_hit,
   input wire [1:0] bank_port_size,
   input wire [1:0] bank_page_mode,
   input wire [`TIMING_W-1:0] row_to_col_extra,
   input wire [`TIMING_W-1:0] col_strobe_extra,
   input wire [`TIMING_W-1:0] row_precharge_extra,
   input wire [`TIMING_W-1:0] col_precharge_extra,
   input wire address_mux_drive_enable,
   input wire refresh_busy,
   output wire busy
);
   // =========================================================
   // states
   // =========================================================
   localparam [7:0] ST_IDLE = 8'h01; // waiting for start strobe
   localparam [7:0] ST_WAIT = 8'h02; // refresh or precharge hold-off
   localparam [7:0] ST_ROW = 8'h04; // row address out, row strobe next
   localparam [7:0] ST_COL = 8'h08; // column address out
   localparam [7:0] ST_CAS = 8'h10; // column strobe asserted
   localparam [7:0] ST_ACK = 8'h20; // acknowledge asserted
   localparam [7:0] ST_PRE = 8'h40; // between beats precharge
   localparam [7:0] ST_TAIL = 8'h80; // acknowledge still driven high

   // =========================================================
   // helper functions
   // =========================================================
   // number of beats after the first needed for operand on this port
   function [`BEAT_CNT_W-1:0] beats_for;
      input [1:0] width;
      input [1:0] port;
      reg [`BEAT_CNT_W-1:0] bytes;
      reg [`BEAT_CNT_W-1:0] lanes;
      begin
         bytes = 4'h4;
         lanes = 4'h4;
         case (width)
            `SIZE_BYTE: bytes = 4'h1;
            `SIZE_WORD: bytes = 4'h2;
            `SIZE_LINE: bytes = 4'hF; // sixteen bytes, held as count-1 below
            default: bytes = 4'h4;
         endcase
         case (port)
            `PORT_8: lanes = 4'h1;
            `PORT_16: lanes = 4'h2;
            default: lanes = 4'h4;
         endcase
         if (width == `SIZE_LINE) begin
            beats_for = (port == `PORT_8) ? 4'hF : ((port == `PORT_16) ? 4'h7 : 4'h3);
         end else if (bytes <= lanes) begin
            beats_for = 4'h0;
         end else begin
            beats_for = (bytes / lanes) - 4'h1;
         end
      end
   endfunction

   // column strobes for the port width
   function [3:0] lanes_for;
      input [1:0] port;
      begin
         if (port == `PORT_8) begin
            lanes_for = 4'h1;
         end else if (port == `PORT_16) begin
            lanes_for = 4'h3;
         end else begin
            lanes_for = 4'hF;
         end
      end
   endfunction

   // column address advanced by one port width
   function [`ADDR_W-1:0] step_col;
      input [`ADDR_W-1:0] addr;
      input [1:0] port;
      begin
         if (port == `PORT_8) begin
            step_col = addr + `COL_STEP_8;
         end else if (port == `PORT_16) begin
            step_col = addr + `COL_STEP_16;
         end else begin
            step_col = addr + `COL_STEP_32;
         end
      end
   endfunction

   // =========================================================
   // state and latched request
   // =========================================================
   reg [7:0] state; // current state
   reg [7:0] next_state; // next state
   reg [`ADDR_W-1:0] addr_latch; // registered start address
   reg [`ADDR_W-1:0] col_addr; // incrementing column address
   reg read_latch; // registered direction
   reg [1:0] port_latch; // port size of hit bank
   reg page_burst; // bank behaves as burst page mode
   reg [`BEAT_CNT_W-1:0] beats_left; // beats after the current one
   reg row_open; // row strobe held between beats
   reg start_hit; // start strobe seen to a dram bank
   reg load_timer; // reload phase counter
   reg [`TIMING_W-1:0] timer_value; // extra cycles for next phase
   wire timer_done; // phase extension elapsed
   wire [3:0] lanes; // active column strobes
   reg row_req; // rising-edge row strobe request
   reg col_req; // rising-edge column strobe request
   wire [`ADDR_W-1:0] col_step_addr; // column of the next beat
   wire [`ADDR_W-1:0] col_now; // column to put on the bus next

   assign col_step_addr = step_col(col_addr, port_latch);
   // a page beat straight out of the acknowledge uses the stepped column
   assign col_now = (state == ST_ACK) ? col_step_addr : col_addr;
   assign lanes = lanes_for(port_latch);
   assign busy = (state != ST_IDLE);
   assign data_oe_n = 1'b1;

   // =========================================================
   // phase stretching and strobe retiming
   // =========================================================
   phase_counter u_phase (
      .clk(clk),
      .reset(reset),
      .load(load_timer),
      .load_value(timer_value),
      .done(timer_done)
   );

   half_cycle_strobes u_strobes (
      .clk(clk),
      .reset(reset),
      .row_req(row_req),
      .col_req(col_req ? lanes : 4'h0),
      .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n)
   );

   // =========================================================
   // next state
   // =========================================================
   always @* begin
      next_state = state;
      load_timer = 1'b0;
      timer_value = {`TIMING_W{1'b0}};
      start_hit = !transfer_start_strobe_n && bank_hit;
      case (state)
         ST_IDLE, ST_TAIL: begin
            if (start_hit) begin
               next_state = ST_WAIT;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            // refresh finished and row precharge met
            if (!refresh_busy && timer_done) begin
               next_state = ST_ROW;
               load_timer = 1'b1;
               timer_value = row_to_col_extra;
            end
         end
         ST_ROW: begin
            if (timer_done) begin
               next_state = ST_COL;
            end
         end
         ST_COL: begin
            // stretch the column strobe only when extra cycles are asked for
            if (col_strobe_extra == {`TIMING_W{1'b0}}) begin
               next_state = ST_ACK;
            end else begin
               next_state = ST_CAS;
               load_timer = 1'b1;
               timer_value = col_strobe_extra - {{(`TIMING_W-1){1'b0}}, 1'b1};
            end
         end
         ST_CAS: begin
            if (timer_done) begin
               next_state = ST_ACK;
            end
         end
         ST_ACK: begin
            if (beats_left == {`BEAT_CNT_W{1'b0}}) begin
               next_state = ST_TAIL;
               load_timer = 1'b1;
               timer_value = row_precharge_extra;
            end else if (page_burst && col_precharge_extra == {`TIMING_W{1'b0}}) begin
               next_state = ST_COL;
            end else if (page_burst) begin
               next_state = ST_PRE;
               load_timer = 1'b1;
               timer_value = col_precharge_extra - {{(`TIMING_W-1){1'b0}}, 1'b1};
            end else begin
               next_state = ST_PRE;
               load_timer = 1'b1;
               timer_value = row_precharge_extra;
            end
         end
         ST_PRE: begin
            if (timer_done) begin
               if (page_burst) begin
                  next_state = ST_COL;
               end else begin
                  next_state = ST_ROW;
                  load_timer = 1'b1;
                  timer_value = row_to_col_extra;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // =========================================================
   // sequencing registers
   // =========================================================
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         addr_latch <= {`ADDR_W{1'b0}};
         col_addr <= {`ADDR_W{1'b0}};
         read_latch <= 1'b1;
         port_latch <= `PORT_32;
         page_burst <= 1'b0;
         beats_left <= {`BEAT_CNT_W{1'b0}};
         row_open <= 1'b0;
      end else begin
         state <= next_state;
         if ((state == ST_IDLE || state == ST_TAIL) && start_hit) begin
            addr_latch <= addr_in;
            col_addr <= addr_in;
            read_latch <= read_not_write;
            port_latch <= bank_port_size;
            // fast page banks run as burst page here
            page_burst <= (bank_page_mode != `PAGE_NORMAL);
            beats_left <= beats_for(operand_width_code, bank_port_size);
            row_open <= 1'b0;
         end
         if (state == ST_ACK && beats_left != {`BEAT_CNT_W{1'b0}}) begin
            beats_left <= beats_left - {{(`BEAT_CNT_W-1){1'b0}}, 1'b1};
            // step column by one port width
            col_addr <= col_step_addr;
         end
         // nonburst in page mode closes the row like normal mode
         row_open <= (next_state == ST_PRE) && page_burst;
      end
   end

   // =========================================================
   // strobe requests, retimed to falling edge
   // =========================================================
   always @* begin
      row_req = 1'b0;
      col_req = 1'b0;
      if (state == ST_ROW || state == ST_COL || state == ST_CAS || state == ST_ACK) begin
         row_req = 1'b1;
      end
      if (state == ST_PRE && row_open) begin
         row_req = 1'b1;
      end
      if (state == ST_COL || state == ST_CAS) begin
         col_req = 1'b1;
      end
      // column strobe held through the beat unless a page beat follows
      if (state == ST_ACK && !(page_burst && beats_left != {`BEAT_CNT_W{1'b0}})) begin
         col_req = 1'b1;
      end
   end

   // =========================================================
   // address, write strobe and acknowledge outputs
   // =========================================================
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         addr_out <= {`ADDR_W{1'b0}};
         addr_oe_n <= 1'b1;
         dram_write_strobe <= 1'b1;
         transfer_acknowledge_n <= 1'b1;
         transfer_acknowledge_oe_n <= 1'b1;
      end else begin
         case (next_state)
            ST_ROW: begin
               addr_out <= (state == ST_PRE) ? col_addr : addr_latch;
               addr_oe_n <= ~address_mux_drive_enable;
               dram_write_strobe <= read_latch;
            end
            ST_COL, ST_CAS: begin
               // column bits shifted onto the row field
               addr_out <= {col_now[`ROW_LSB-1:0], col_now[`ADDR_W-1:`ROW_LSB]};
               addr_oe_n <= ~address_mux_drive_enable;
            end
            ST_TAIL, ST_IDLE, ST_WAIT: begin
               addr_oe_n <= 1'b1;
            end
            default: begin
               addr_oe_n <= addr_oe_n;
            end
         endcase
         if (next_state == ST_ACK) begin
            transfer_acknowledge_n <= 1'b0;
         end else begin
            transfer_acknowledge_n <= 1'b1;
         end
         if (next_state == ST_COL || next_state == ST_CAS || next_state == ST_ACK ||
             next_state == ST_PRE || next_state == ST_ROW && state == ST_PRE) begin
            transfer_acknowledge_oe_n <= 1'b0;
         end else if (state == ST_ACK) begin
            transfer_acknowledge_oe_n <= 1'b0;
         end else begin
            transfer_acknowledge_oe_n <= 1'b1;
         end
         if (next_state == ST_IDLE || next_state == ST_TAIL) begin
            dram_write_strobe <= 1'b1;
         end
      end
   end
endmodule // alt_master_dram_sequencer

// ===== sim/alt_master_dram_sequencer_props.sv
// concurrent checks on the alternate master dram sequencer ports
`timescale 1ns/1ps
module alt_master_dram_sequencer_props (
   input wire clk,
   input wire reset,
   input wire transfer_start_strobe_n,
   input wire bank_hit,
   input wire busy,
   input wire refresh_busy,
   input wire transfer_acknowledge_n,
   input wire transfer_acknowledge_oe_n,
   input wire data_oe_n,
   input wire row_strobe_n,
   input wire [3:0] col_strobe_n,
   input wire dram_write_strobe,
   input wire addr_oe_n,
   input wire address_mux_drive_enable,
   input wire [1:0] bank_page_mode
);
   // ==========
   // clocking and sequences
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // start taken from idle with no refresh pending
   sequence taken_s;
      !transfer_start_strobe_n && bank_hit && !busy && !refresh_busy;
   endsequence
   // one acknowledge beat
   sequence ack_beat_s;
      !transfer_acknowledge_n;
   endsequence
   // ==========
   // assertions
   AST_FIRST_ACK: assert property (taken_s |-> transfer_acknowledge_n [*4] ##1 ack_beat_s)
      else $error("first acknowledge not four clocks after start");
   AST_ACK_ONE: assert property (ack_beat_s |=> transfer_acknowledge_n)
      else $error("acknowledge longer than one clock");
   AST_ACK_DRIVEN: assert property (ack_beat_s |-> !transfer_acknowledge_oe_n)
      else $error("acknowledge asserted while not driven");
   AST_ACK_RELEASE: assert property ($rose(transfer_acknowledge_oe_n) |->
      $past(transfer_acknowledge_n, 1) && !$past(transfer_acknowledge_n, 2))
      else $error("acknowledge released at wrong time");
   AST_ACK_HAS_CAS: assert property (ack_beat_s |-> $past(col_strobe_n) != 4'hF)
      else $error("acknowledge without column strobe");
   AST_CAS_HOLD: assert property (!transfer_acknowledge_n && bank_page_mode == 2'h0 |->
      col_strobe_n != 4'hF)
      else $error("column strobe dropped before normal beat end");
   AST_CAS_UNDER_ROW: assert property (col_strobe_n != 4'hF |-> !row_strobe_n)
      else $error("column strobe without row strobe");
   AST_NO_DATA_DRIVE: assert property (data_oe_n)
      else $error("data bus driven");
   AST_ADDR_OFF: assert property (!address_mux_drive_enable |-> addr_oe_n)
      else $error("address driven while drive disabled");
   AST_IDLE_READ_LEVEL: assert property (!busy |-> dram_write_strobe)
      else $error("write strobe low while idle");
   AST_REFRESH_HOLD: assert property (refresh_busy && !busy |=> row_strobe_n)
      else $error("row strobe during refresh");
   AST_NORMAL_PRECHARGE: assert property (!transfer_acknowledge_n && bank_page_mode == 2'h0 |=>
      row_strobe_n)
      else $error("row strobe not negated after normal beat");
   AST_REFUSE_MISS: assert property (!transfer_start_strobe_n && !bank_hit && !busy |=>
      !busy)
      else $error("start without hit was taken");
endmodule // alt_master_dram_sequencer_props

bind alt_master_dram_sequencer alt_master_dram_sequencer_props i_props (
   .clk(clk), .reset(reset), .transfer_start_strobe_n(transfer_start_strobe_n),
   .bank_hit(bank_hit), .busy(busy), .refresh_busy(refresh_busy),
   .transfer_acknowledge_n(transfer_acknowledge_n), .data_oe_n(data_oe_n),
   .transfer_acknowledge_oe_n(transfer_acknowledge_oe_n), .row_strobe_n(row_strobe_n),
   .col_strobe_n(col_strobe_n), .dram_write_strobe(dram_write_strobe), .addr_oe_n(addr_oe_n),
   .address_mux_drive_enable(address_mux_drive_enable), .bank_page_mode(bank_page_mode));

// ===== sim/alt_master_model.sv
// alternate bus master model driving start strobe, address and attributes
`timescale 1ns/1ps
module alt_master_model (
   input wire clk,
   input wire reset,
   input wire go,
   input wire [27:0] go_addr,
   input wire go_rnw,
   input wire [1:0] go_width,
   output reg start_n,
   output reg [27:0] addr,
   output reg rnw,
   output reg [1:0] width
);
   // ==========
   // request driver
   // one strobe per transfer or burst; address released right after the start edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         start_n <= 1'b1;
         addr <= 28'h0000000;
         rnw <= 1'b1;
         width <= 2'h0;
      end else if (go) begin
         start_n <= 1'b0;
         addr <= go_addr;
         rnw <= go_rnw;
         width <= go_width;
      end else begin
         // released address shows a changing pattern, never the last value; rnw and width hold theirs
         start_n <= 1'b1;
         addr <= ~addr;
      end
   end
endmodule // alt_master_model

// ===== sim/testbench.sv
// self-checking testbench for the alternate master dram sequencer
`timescale 1ns/1ps
`include "alt_dram_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
   // ==========
   // stimulus and observed nets
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg go = 1'b0;
   reg [27:0] m_addr = 28'h0000000;
   reg m_rnw = 1'b1;
   reg [1:0] m_width = 2'h0;
   reg bank_hit = 1'b1;
   reg [1:0] port = 2'h0;
   reg [1:0] mode = 2'h0;
   reg [3:0] row_pre = 4'h0;
   reg [3:0] col_pre = 4'h0;
   reg drive_en = 1'b1;
   reg refresh_busy = 1'b0;
   wire start_n, rnw, busy, ack_n, ack_oe_n, data_oe_n, row_n, dram_write_strobe, addr_oe_n;
   wire [27:0] m_bus;
   wire [27:0] addr_out;
   wire [1:0] width;
   wire [3:0] col_n;
   int err_total = 0;
   int checks = 0;
   int lat, gap, nb, row_hi, rel, pend;
   reg [3:0] cas;
   reg ws1, ws2, fl, oe_seen;
   reg [27:0] row_addr;
   // free-running clock
   always #12.5 clk = ~clk;
   // ==========
   // instances
   alt_master_model i_alt_master_model (.clk(clk), .reset(reset), .go(go), .go_addr(m_addr),
      .go_rnw(m_rnw), .go_width(m_width), .start_n(start_n), .addr(m_bus), .rnw(rnw),
      .width(width));
   alt_master_dram_sequencer i_alt_master_dram_sequencer (.clk(clk), .reset(reset),
      .transfer_start_strobe_n(start_n), .addr_in(m_bus), .read_not_write(rnw),
      .operand_width_code(width), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
      .transfer_acknowledge_n(ack_n), .transfer_acknowledge_oe_n(ack_oe_n),
      .data_oe_n(data_oe_n), .row_strobe_n(row_n), .col_strobe_n(col_n),
      .dram_write_strobe(dram_write_strobe), .bank_hit(bank_hit), .bank_port_size(port),
      .bank_page_mode(mode), .row_to_col_extra(4'h0), .col_strobe_extra(4'h0),
      .row_precharge_extra(row_pre), .col_precharge_extra(col_pre),
      .address_mux_drive_enable(drive_en), .refresh_busy(refresh_busy), .busy(busy));
   // ==========
   // transfer runner: launches one start, a second when chained, and measures beats after each edge
   task automatic run(input [27:0] a, input r, input [1:0] w, input c);
      int i;
      int t0;
      int tl;
      begin
         t0 = -1;
         tl = 0;
         nb = 0;
         row_hi = 0;
         pend = 0;
         rel = 0;
         oe_seen = 1'b0;
         @(posedge clk);
         m_addr <= a;
         m_rnw <= r;
         m_width <= w;
         go <= 1'b1;
         for (i = 0; i < 80; i++) begin
            @(posedge clk);
            go <= 1'b0;
            #1;
            if (t0 < 0 && start_n === 1'b0) t0 = i;
            if (addr_oe_n === 1'b0 && !oe_seen) begin
               oe_seen = 1'b1;
               row_addr = addr_out;
            end
            if (nb > 0 && i == tl + 1) fl = addr_oe_n;
            if (nb > 0 && rel == 0 && ack_oe_n === 1'b1) rel = i - tl;
            if (nb > 0 && row_n === 1'b1) pend = 1;
            if (ack_n === 1'b0) begin
               if (nb == 0) lat = i - t0;
               else gap = i - tl;
               if (nb == 0) ws1 = dram_write_strobe;
               row_hi = row_hi | pend;
               pend = 0;
               tl = i;
               nb++;
               cas = col_n;
               ws2 = dram_write_strobe;
               // chained write starts as soon as the address floats
               if (c && nb == 1) begin
                  m_rnw <= 1'b0;
                  go <= 1'b1;
               end
            end
            if (t0 >= 0 && i > t0 + 2 && busy === 1'b0 && ack_oe_n === 1'b1) break;
         end
      end
   endtask
   // ==========
   // scenarios
   task t_read_b2b;
      begin
         @(posedge clk);
         port <= `PORT_8;
         run(28'h0ABCDEF, 1'b1, `SIZE_BYTE, 1'b1);
         `CHK("lat", 4, lat)
         `CHK("beats", 2, nb)
         `CHK("gap", 5, gap)
         `CHK("cas", 4'hE, cas)
         `CHK("ws1", 1'b1, ws1)
         `CHK("ws2", 1'b0, ws2)
         `CHK("row_addr", 28'h0ABCDEF, row_addr)
         `CHK("float", 1'b1, fl)
         `CHK("release", 2, rel)
         $display("test read_b2b done");
      end
   endtask
   task t_norm_burst;
      begin
         @(posedge clk);
         port <= `PORT_16;
         run(28'h0123400, 1'b0, `SIZE_LONG, 1'b0);
         `CHK("beats", 2, nb)
         `CHK("gap", 4, gap)
         `CHK("row_hi", 1, row_hi)
         `CHK("cas", 4'hC, cas)
         `CHK("lat", 4, lat)
         @(posedge clk);
         row_pre <= 4'h2;
         run(28'h0123400, 1'b0, `SIZE_LONG, 1'b0);
         `CHK("slow_gap", 1'b1, gap > 4)
         @(posedge clk);
         row_pre <= 4'h0;
         $display("test norm_burst done");
      end
   endtask
   task t_page;
      begin
         @(posedge clk);
         port <= `PORT_8;
         mode <= `PAGE_FAST;
         run(28'h0000210, 1'b1, `SIZE_WORD, 1'b0);
         `CHK("beats", 2, nb)
         `CHK("gap", 2, gap)
         `CHK("row_hi", 0, row_hi)
         @(posedge clk);
         port <= `PORT_32;
         mode <= `PAGE_BURST;
         run(28'h0000300, 1'b1, `SIZE_LONG, 1'b0);
         `CHK("beats", 1, nb)
         `CHK("lat", 4, lat)
         `CHK("float", 1'b1, fl)
         @(posedge clk);
         col_pre <= 4'h1;
         run(28'h0000400, 1'b0, `SIZE_LINE, 1'b0);
         `CHK("beats", 4, nb)
         `CHK("cas", 4'h0, cas)
         `CHK("slow_gap", 1'b1, gap > 2)
         @(posedge clk);
         col_pre <= 4'h0;
         $display("test page done");
      end
   endtask
   task t_hold_offs;
      begin
         @(posedge clk);
         drive_en <= 1'b0;
         run(28'h0000500, 1'b1, `SIZE_LONG, 1'b0);
         `CHK("addr_driven", 1'b0, oe_seen)
         `CHK("beats", 1, nb)
         @(posedge clk);
         drive_en <= 1'b1;
         refresh_busy <= 1'b1;
         fork
            run(28'h0000600, 1'b1, `SIZE_LONG, 1'b0);
            begin
               repeat (6) @(posedge clk);
               refresh_busy <= 1'b0;
            end
         join
         `CHK("late", 1'b1, lat > 4)
         @(posedge clk);
         bank_hit <= 1'b0;
         run(28'h0000700, 1'b1, `SIZE_LONG, 1'b0);
         `CHK("beats", 0, nb)
         `CHK("addr_driven", 1'b0, oe_seen)
         @(posedge clk);
         bank_hit <= 1'b1;
         $display("test hold_offs done");
      end
   endtask
   // ==========
   // verdict, main sequence and watchdog
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", checks, err_total);
         if (err_total == 0 && checks > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // reset for two clocks, then every scenario in turn
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_read_b2b;
      t_norm_burst;
      t_page;
      t_hold_offs;
      wrap_up;
   end
   // cut a hang short well past the expected run length
   initial begin
      #75000;
      err_total++;
      wrap_up;
   end
endmodule // testbench
